// file: src/cid_pkg.sv
// shared constants, encodings and carrier types of the instruction decode and timing block
package cid_pkg;

   // ************************************************************
   // word layout
   // ************************************************************
   localparam int unsigned INSTR_W      = 14;
   localparam int unsigned LOC_W        = 7;
   localparam int unsigned BITPOS_W     = 3;
   localparam int unsigned LIT_W        = 8;
   localparam int unsigned TARGET_W     = 11;
   localparam int unsigned DEST_POS     = 7;
   localparam int unsigned BITPOS_LSB   = 7;
   localparam int unsigned PTR_POS_CTL  = 2;
   localparam int unsigned PTR_POS_OFS  = 6;

   // ************************************************************
   // operation code patterns (x positions are don't care)
   // ************************************************************
   localparam logic [13:0] OPC_CONTROL  = 14'b00_0000_0???_????;
   localparam logic [13:0] OPC_BYTE     = 14'b00_????_????_????;
   localparam logic [13:0] OPC_DECSKIP  = 14'b00_1011_????_????;
   localparam logic [13:0] OPC_INCSKIP  = 14'b00_1111_????_????;
   localparam logic [13:0] OPC_SKIPCLR  = 14'b01_10??_????_????;
   localparam logic [13:0] OPC_SKIPSET  = 14'b01_11??_????_????;
   localparam logic [13:0] OPC_BIT      = 14'b01_????_????_????;
   localparam logic [13:0] OPC_SUBJUMP  = 14'b10_0???_????_????;
   localparam logic [13:0] OPC_ABSJUMP  = 14'b10_1???_????_????;
   localparam logic [13:0] OPC_EXITLIT  = 14'b11_0100_????_????;
   localparam logic [13:0] OPC_RELJUMP  = 14'b11_001?_????_????;
   localparam logic [13:0] OPC_PTROFS   = 14'b11_1111_????_????;
   localparam logic [13:0] OPC_SUBEXIT  = 14'h0008;
   localparam logic [13:0] OPC_INTEXIT  = 14'h0009;
   localparam logic [13:0] OPC_CSUBJUMP = 14'h000A;
   localparam logic [13:0] OPC_CRELJUMP = 14'h000B;
   localparam logic [13:0] OPC_PTRSTEP  = 14'b00_0000_0001_????;

   // file locations that alias the two indirect access ports
   localparam logic [6:0]  LOC_INDIRECT = 7'b000_000?;

   // ************************************************************
   // timing
   // ************************************************************
   localparam int unsigned OSC_PER_CYC  = 4;
   localparam logic [1:0]  REMAIN_ONE   = 2'h1;

   // ************************************************************
   // types
   // ************************************************************
   typedef enum logic [1:0] {
      FMT_BYTE = 2'b00,
      FMT_BIT  = 2'b01,
      FMT_LIT  = 2'b10
   } cid_fmt_type;

   typedef enum logic [2:0] {
      OP_PLAIN = 3'b000,
      OP_CALL  = 3'b001,
      OP_EXIT  = 3'b010,
      OP_JUMP  = 3'b011,
      OP_SKIP  = 3'b100
   } cid_op_type;

   typedef enum logic [1:0] {
      STEP_PRE_INC  = 2'b00,
      STEP_PRE_DEC  = 2'b01,
      STEP_POST_INC = 2'b10,
      STEP_POST_DEC = 2'b11
   } cid_step_type;

   typedef enum logic [1:0] {
      PH_Q1 = 2'b00,
      PH_Q2 = 2'b01,
      PH_Q3 = 2'b10,
      PH_Q4 = 2'b11
   } cid_phase_type;

   typedef struct packed {
      cid_fmt_type           fmt;
      cid_op_type            op;
      logic                  dest_file;
      logic [LOC_W-1:0]      reg_loc;
      logic [BITPOS_W-1:0]   bit_pos;
      logic [LIT_W-1:0]      literal;
      logic [TARGET_W-1:0]   target;
      logic                  ptr_sel;
      cid_step_type          step;
      logic                  ptr_step_op;
      logic                  file_op;
      logic                  indirect;
   } cid_fields_type;

endpackage : cid_pkg

// file: src/cid_phase_gen.sv
// four-phase divider that builds one instruction cycle from four oscillator cycles
`timescale 1ns/1ps
module cid_phase_gen (
   // clock and reset
   input  wire logic                   i_core_clk,
   input  wire logic                   i_rst,
   // phase
   output cid_pkg::cid_phase_type      o_phase
);
   import cid_pkg::*;

   typedef struct packed {
      cid_phase_type phase;
   } cid_pg_state_type;

   cid_pg_state_type st_reg;
   cid_pg_state_type st_next;

   // free running: Q1 Q2 Q3 Q4 then back to Q1
   always_comb begin
      st_next       = st_reg;
      st_next.phase = cid_phase_type'(2'(st_reg.phase + 2'h1));
   end

   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         st_reg.phase <= PH_Q1;
      end else begin
         st_reg <= st_next;
      end
   end

   assign o_phase = st_reg.phase;

endmodule : cid_phase_gen

// file: src/cid_field_dec.sv
// combinational split of a 14-bit instruction word into format, class and operand fields
`timescale 1ns/1ps
module cid_field_dec (
   // word
   input  wire logic [13:0]            i_word,
   // fields
   output cid_pkg::cid_fields_type     o_fields
);
   import cid_pkg::*;

   always_comb begin
      o_fields             = '0;
      o_fields.dest_file   = i_word[DEST_POS];
      o_fields.reg_loc     = i_word[LOC_W-1:0];
      o_fields.bit_pos     = i_word[BITPOS_LSB +: BITPOS_W];
      o_fields.literal     = i_word[LIT_W-1:0];
      o_fields.target      = i_word[TARGET_W-1:0];
      o_fields.step        = cid_step_type'(i_word[1:0]);
      o_fields.ptr_sel     = i_word[PTR_POS_CTL];
      // wildcard matching keeps don't care positions out of every compare
      casez (i_word)
         OPC_SUBEXIT, OPC_INTEXIT: begin
            o_fields.fmt = FMT_LIT;
            o_fields.op  = OP_EXIT;
         end
         OPC_CSUBJUMP: begin
            o_fields.fmt = FMT_LIT;
            o_fields.op  = OP_CALL;
         end
         OPC_CRELJUMP: begin
            o_fields.fmt = FMT_LIT;
            o_fields.op  = OP_JUMP;
         end
         OPC_PTRSTEP: begin
            o_fields.fmt         = FMT_LIT;
            o_fields.ptr_step_op = 1'b1;
            o_fields.indirect    = 1'b1;
         end
         OPC_CONTROL: o_fields.fmt = FMT_LIT;
         OPC_DECSKIP, OPC_INCSKIP: begin
            o_fields.fmt     = FMT_BYTE;
            o_fields.op      = OP_SKIP;
            o_fields.file_op = 1'b1;
         end
         OPC_BYTE: begin
            o_fields.fmt     = FMT_BYTE;
            o_fields.file_op = 1'b1;
         end
         OPC_SKIPCLR, OPC_SKIPSET: begin
            o_fields.fmt     = FMT_BIT;
            o_fields.op      = OP_SKIP;
            o_fields.file_op = 1'b1;
         end
         OPC_BIT: begin
            o_fields.fmt     = FMT_BIT;
            o_fields.file_op = 1'b1;
         end
         OPC_SUBJUMP: begin
            o_fields.fmt = FMT_LIT;
            o_fields.op  = OP_CALL;
         end
         OPC_ABSJUMP: begin
            o_fields.fmt = FMT_LIT;
            o_fields.op  = OP_JUMP;
         end
         OPC_EXITLIT: begin
            o_fields.fmt = FMT_LIT;
            o_fields.op  = OP_EXIT;
         end
         OPC_RELJUMP: begin
            o_fields.fmt = FMT_LIT;
            o_fields.op  = OP_JUMP;
         end
         OPC_PTROFS: begin
            o_fields.fmt      = FMT_LIT;
            o_fields.ptr_sel  = i_word[PTR_POS_OFS];
            o_fields.indirect = 1'b1;
         end
         default: o_fields.fmt = FMT_LIT;
      endcase
      // a file access to an indirect port goes through the pointer named by its low bit
      if (o_fields.file_op && (o_fields.reg_loc ==? LOC_INDIRECT)) begin
         o_fields.indirect = 1'b1;
         o_fields.ptr_sel  = o_fields.reg_loc[0];
      end
   end

endmodule : cid_field_dec

// file: src/cid_decode_timing.sv
// instruction decode and execution timing of the 8-bit core
//
// How it works
// - each instruction arrives as one 14-bit word with opcode and all operands
// - every opcode falls into byte, bit, or literal/control format
// - instructions outside the exceptions finish in one instruction cycle
// - both subroutine jumps take two instruction cycles
// - the three exits take two instruction cycles
// - jumps and the four skips take two instruction cycles
// - indirect access pointing into program memory adds one cycle
// - one instruction cycle is four oscillator cycles
// - file instructions read, modify, then write, except bit skips, which only read; the read always happens
// - destination bit 0 writes the accumulator, 1 the file register
// - register location addresses 0x00 to 0x7F in the selected bank
// - bit position picks one bit of the addressed 8-bit register
// - pointer select picks pointer pair 0 or 1
// - auto step picks pre/post increment/decrement of the pointer
// - don't care positions are ignored; tools should emit zero there
// - bit position is a 3-bit field
// - literal/control words carry an 8-bit immediate in the low byte
// - absolute and subroutine jumps carry an 11-bit target
`timescale 1ns/1ps
module cid_decode_timing (
   // clock and reset
   input  wire logic                   i_core_clk,
   input  wire logic                   i_rst,
   // fetched word from program memory
   input  wire logic [13:0]            i_instr,
   input  wire logic                   i_instr_valid,
   output logic                        o_issue_ready,
   // core status
   input  wire logic [1:0]             i_ptr_in_prog,
   input  wire logic                   i_skip_cond,
   // decoded instruction
   output cid_pkg::cid_fields_type     o_fields,
   output logic                        o_active,
   output logic                        o_first_cyc,
   output logic                        o_extra_cyc,
   output cid_pkg::cid_phase_type      o_phase,
   // register file strobes
   output logic                        o_reg_rd,
   output logic                        o_reg_wr,
   output logic                        o_wr_acc,
   // fetch path
   output logic                        o_flush
);
   import cid_pkg::*;

   // ************************************************************
   // state
   // ************************************************************
   typedef struct packed {
      cid_fields_type  fields;
      logic            active;
      logic            first;
      logic            extra;
      logic [1:0]      remain;
      logic            flush;
   } cid_dt_state_type;

   cid_dt_state_type  st_reg;
   cid_dt_state_type  st_next;
   cid_fields_type    dec_fields;
   cid_phase_type     phase;
   logic              take;
   logic              pm_extra;
   logic [1:0]        base_cycles;
   logic              redirect;

   // ************************************************************
   // leaves
   // ************************************************************
   cid_phase_gen u_phase (
      .i_core_clk (i_core_clk),
      .i_rst      (i_rst),
      .o_phase    (phase)
   );

   cid_field_dec u_dec (
      .i_word     (i_instr),
      .o_fields   (dec_fields)
   );

   // ************************************************************
   // cycle budget
   // ************************************************************
   always_comb begin
      unique case (dec_fields.op)
         OP_PLAIN: base_cycles = 2'h1;
         OP_CALL:  base_cycles = 2'h2;
         OP_EXIT:  base_cycles = 2'h2;
         OP_JUMP:  base_cycles = 2'h2;
         OP_SKIP:  base_cycles = 2'h2;
         default:  base_cycles = 2'h1;
      endcase
   end

   // pointer pair that the word selects decides the extra cycle
   assign pm_extra = dec_fields.indirect & i_ptr_in_prog[dec_fields.ptr_sel];

   // a new word is only taken at the close of an instruction cycle
   assign take = (phase == PH_Q4) & i_instr_valid & o_issue_ready;

   // jumps and exits always redirect; a skip only when its test succeeds
   always_comb begin
      unique case (st_reg.fields.op)
         OP_CALL, OP_EXIT, OP_JUMP: redirect = 1'b1;
         OP_SKIP:                   redirect = i_skip_cond;
         default:                   redirect = 1'b0;
      endcase
   end

   // ************************************************************
   // sequencing
   // ************************************************************
   always_comb begin
      st_next       = st_reg;
      st_next.flush = 1'b0;
      if (phase == PH_Q4) begin
         // the fetch path sees flush during the cycle after the first one
         if (st_reg.active && st_reg.first && redirect) begin
            st_next.flush = 1'b1;
         end
         if (st_reg.remain != 2'h0) begin
            st_next.remain = 2'(st_reg.remain - 2'h1);
            st_next.first  = 1'b0;
         end else if (take) begin
            st_next.fields = dec_fields;
            st_next.active = 1'b1;
            st_next.first  = 1'b1;
            st_next.extra  = pm_extra;
            st_next.remain = 2'(base_cycles - 2'h1 + {1'b0, pm_extra});
         end else begin
            st_next.active = 1'b0;
            st_next.first  = 1'b0;
            st_next.extra  = 1'b0;
         end
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   // ************************************************************
   // outputs
   // ************************************************************
   assign o_issue_ready = (st_reg.remain == 2'h0);
   assign o_fields      = st_reg.fields;
   assign o_active      = st_reg.active;
   assign o_first_cyc   = st_reg.first;
   assign o_extra_cyc   = st_reg.extra;
   assign o_phase       = phase;
   assign o_flush       = st_reg.flush;

   // read in Q2 and write in Q4 of the first cycle, even for write-only operations
   assign o_reg_rd = st_reg.active & st_reg.first & st_reg.fields.file_op & (phase == PH_Q2);
   // plain bit operations always go back to the file; byte skips follow their destination bit; bit skips write nothing
   assign o_reg_wr = st_reg.active & st_reg.first & st_reg.fields.file_op & (phase == PH_Q4)
                     & (st_reg.fields.op == OP_PLAIN || st_reg.fields.fmt == FMT_BYTE);
   assign o_wr_acc = o_reg_wr & (st_reg.fields.fmt == FMT_BYTE) & ~st_reg.fields.dest_file;

   // ************************************************************
   // checks
   // ************************************************************
   sequence seq_busy_cycle;
      !o_issue_ready [*4];
   endsequence

   sequence seq_free_cycle;
      o_issue_ready [*4];
   endsequence

   sequence seq_take_single;
      take && (base_cycles == 2'h1) && !pm_extra;
   endsequence

   sequence seq_take_double(cid_op_type kind);
      take && (dec_fields.op == kind) && !pm_extra;
   endsequence

   chk_phase_wrap: assert property (@(posedge i_core_clk) disable iff (i_rst)
      (phase == PH_Q4) |=> (phase == PH_Q1) ##1 (phase == PH_Q2) ##1 (phase == PH_Q3))
      else $error("phase sequence broken");

   chk_single_cycle: assert property (@(posedge i_core_clk) disable iff (i_rst)
      seq_take_single |=> seq_free_cycle)
      else $error("one cycle instruction held issue");

   chk_call_two: assert property (@(posedge i_core_clk) disable iff (i_rst)
      seq_take_double(OP_CALL) |=> seq_busy_cycle ##1 seq_free_cycle)
      else $error("subroutine jump not two cycles");

   chk_exit_two: assert property (@(posedge i_core_clk) disable iff (i_rst)
      seq_take_double(OP_EXIT) |=> seq_busy_cycle ##1 seq_free_cycle)
      else $error("exit not two cycles");

   chk_flow_two: assert property (@(posedge i_core_clk) disable iff (i_rst)
      (seq_take_double(OP_JUMP) or seq_take_double(OP_SKIP)) |=> seq_busy_cycle ##1 seq_free_cycle)
      else $error("program flow not two cycles");

   chk_prog_extra: assert property (@(posedge i_core_clk) disable iff (i_rst)
      (take && pm_extra && base_cycles == 2'h2) |=> seq_busy_cycle ##1 seq_busy_cycle ##1 o_issue_ready)
      else $error("program memory access lacks extra cycle");

   chk_rmw_order: assert property (@(posedge i_core_clk) disable iff (i_rst)
      (take && dec_fields.file_op) |-> ##2 o_reg_rd ##2 (o_reg_wr != (o_fields.fmt == FMT_BIT && o_fields.op == OP_SKIP)))
      else $error("file read before write missing");

   chk_rd_phase: assert property (@(posedge i_core_clk) disable iff (i_rst)
      o_reg_rd |-> (phase == PH_Q2) && o_fields.file_op && $past(phase) == PH_Q1)
      else $error("file read outside Q2");

   chk_dest_sel: assert property (@(posedge i_core_clk) disable iff (i_rst)
      (o_reg_wr && o_fields.fmt == FMT_BYTE) |-> (o_wr_acc == !o_fields.dest_file))
      else $error("destination select wrong");

   chk_fmt_bit: assert property (@(posedge i_core_clk) disable iff (i_rst)
      (take && i_instr[13:12] == 2'b01) |=> (o_fields.fmt == FMT_BIT) && (o_fields.bit_pos == $past(i_instr[9:7])))
      else $error("bit format not decoded");

   chk_jump_flush: assert property (@(posedge i_core_clk) disable iff (i_rst)
      seq_take_double(OP_JUMP) |-> ##5 o_flush ##1 !o_flush)
      else $error("jump did not discard prefetch");

   chk_plain_noflush: assert property (@(posedge i_core_clk) disable iff (i_rst)
      seq_take_single |-> ##1 !o_flush [*5])
      else $error("plain instruction discarded prefetch");

   // a freshly taken word is active and in its first cycle
   sequence seq_loaded;
      o_active && o_first_cyc;
   endsequence

   chk_take_first: assert property (@(posedge i_core_clk) disable iff (i_rst)
      take |=> seq_loaded)
      else $error("taken word not started");

   chk_idle_drop: assert property (@(posedge i_core_clk) disable iff (i_rst)
      (phase == PH_Q4 && o_issue_ready && !take) |=> !o_active)
      else $error("active without a word");

   chk_extra_flag: assert property (@(posedge i_core_clk) disable iff (i_rst)
      take |=> (o_extra_cyc == $past(pm_extra)))
      else $error("extra cycle flag wrong");

   chk_wr_phase: assert property (@(posedge i_core_clk) disable iff (i_rst)
      o_reg_wr |-> (phase == PH_Q4) && o_first_cyc && o_fields.file_op)
      else $error("file write outside Q4");

   chk_rd_before_wr: assert property (@(posedge i_core_clk) disable iff (i_rst)
      o_reg_wr |-> $past(o_reg_rd, 2))
      else $error("file write without read");

   chk_dest_field: assert property (@(posedge i_core_clk) disable iff (i_rst)
      (take && dec_fields.fmt == FMT_BYTE) |=> (o_fields.dest_file == $past(i_instr[7])))
      else $error("destination bit wrong");

   chk_loc_field: assert property (@(posedge i_core_clk) disable iff (i_rst)
      (take && dec_fields.file_op) |=> (o_fields.reg_loc == $past(i_instr[6:0])))
      else $error("register location wrong");

   chk_byte_fmt: assert property (@(posedge i_core_clk) disable iff (i_rst)
      (take && i_instr[13:12] == 2'b00 && i_instr[11:8] != 4'h0) |=> (o_fields.fmt == FMT_BYTE) && o_fields.file_op)
      else $error("byte format not decoded");

   chk_lit_fmt: assert property (@(posedge i_core_clk) disable iff (i_rst)
      (take && i_instr[13]) |=> (o_fields.fmt == FMT_LIT))
      else $error("literal format not decoded");

   chk_lit_field: assert property (@(posedge i_core_clk) disable iff (i_rst)
      take |=> (o_fields.literal == $past(i_instr[7:0])))
      else $error("literal field wrong");

   chk_target_field: assert property (@(posedge i_core_clk) disable iff (i_rst)
      take |=> (o_fields.target == $past(i_instr[10:0])))
      else $error("jump target wrong");

   chk_step_field: assert property (@(posedge i_core_clk) disable iff (i_rst)
      (take && dec_fields.ptr_step_op) |=> (o_fields.step == $past(i_instr[1:0])))
      else $error("auto step field wrong");

   chk_ptr_field: assert property (@(posedge i_core_clk) disable iff (i_rst)
      (take && dec_fields.ptr_step_op) |=> (o_fields.ptr_sel == $past(i_instr[2])))
      else $error("pointer select wrong");

   chk_fields_hold: assert property (@(posedge i_core_clk) disable iff (i_rst)
      !take |=> $stable(o_fields))
      else $error("decode changed without a take");

   chk_flush_pulse: assert property (@(posedge i_core_clk) disable iff (i_rst)
      o_flush |=> !o_flush)
      else $error("flush longer than one clock");

   chk_flush_cause: assert property (@(posedge i_core_clk) disable iff (i_rst)
      o_flush |-> o_active && !o_first_cyc && (o_fields.op != OP_PLAIN))
      else $error("flush without a redirect");

endmodule : cid_decode_timing

// file: testbench/cid_fetch_model.sv
// program memory fetch path model: offers queued words and holds each one until the block takes it
`timescale 1ns/1ps
module cid_fetch_model (
   // clock and reset
   input  wire logic                   i_core_clk,
   input  wire logic                   i_rst,
   // handshake from the block
   input  wire logic                   i_issue_ready,
   input  wire cid_pkg::cid_phase_type i_phase,
   // offered word
   output logic [13:0]                 o_instr,
   output logic                        o_instr_valid
);
   import cid_pkg::*;

   logic [13:0] words[$];
   logic        took;

   task automatic push(input logic [13:0] w);
      words.push_back(w);
   endtask : push

   initial begin
      o_instr       = 14'h0000;
      o_instr_valid = 1'b0;
      took          = 1'b0;
   end

   // the word stays offered until a Q4 edge with ready; idle lines toggle so stale data never looks held
   always @(negedge i_core_clk) begin
      if (took) void'(words.pop_front());
      if (words.size() > 0 && !i_rst) begin
         o_instr_valid = 1'b1;
         o_instr       = words[0];
      end else begin
         o_instr_valid = 1'b0;
         o_instr       = ~o_instr;
      end
      took = o_instr_valid && i_issue_ready && (i_phase == PH_Q4);
   end

endmodule : cid_fetch_model

// file: testbench/cid_decode_timing_tb.sv
// self-checking bench for the instruction decode and timing block
`timescale 1ns/1ps
module cid_decode_timing_tb;
   import cid_pkg::*;

   // ****
   // signals
   // ****
   logic           i_core_clk;
   logic           i_rst;
   logic [13:0]    i_instr;
   logic           i_instr_valid;
   logic           o_issue_ready;
   logic [1:0]     i_ptr_in_prog;
   logic           i_skip_cond;
   cid_fields_type o_fields;
   logic           o_active;
   logic           o_first_cyc;
   logic           o_extra_cyc;
   cid_phase_type  o_phase;
   logic           o_reg_rd;
   logic           o_reg_wr;
   logic           o_wr_acc;
   logic           o_flush;
   int             mismatches;
   int             checked;

   cid_decode_timing dut (
      .i_core_clk    (i_core_clk),
      .i_rst         (i_rst),
      .i_instr       (i_instr),
      .i_instr_valid (i_instr_valid),
      .o_issue_ready (o_issue_ready),
      .i_ptr_in_prog (i_ptr_in_prog),
      .i_skip_cond   (i_skip_cond),
      .o_fields      (o_fields),
      .o_active      (o_active),
      .o_first_cyc   (o_first_cyc),
      .o_extra_cyc   (o_extra_cyc),
      .o_phase       (o_phase),
      .o_reg_rd      (o_reg_rd),
      .o_reg_wr      (o_reg_wr),
      .o_wr_acc      (o_wr_acc),
      .o_flush       (o_flush)
   );

   cid_fetch_model fetch (
      .i_core_clk    (i_core_clk),
      .i_rst         (i_rst),
      .i_issue_ready (o_issue_ready),
      .i_phase       (o_phase),
      .o_instr       (i_instr),
      .o_instr_valid (i_instr_valid)
   );

   // ****
   // shared tasks
   // ****
   task automatic close_out;
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : close_out

   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      checked++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %0t got %0h exp %0h", $time, got, exp);
      end
   endtask : chk

   // issue one word and watch its whole window; e is {read, write, to accumulator, flush}
   task automatic run(input logic [13:0] w, input logic [1:0] ptr, input logic skip, input int n,
                      input logic [3:0] e);
      logic [3:0] rd_n, wr_n, fl_n, lo_n, ph_bad;
      logic [4:0] at;
      int         k;
      {rd_n, wr_n, fl_n, lo_n, ph_bad} = 20'h0;
      at = 5'h00;
      k = 0;
      @(negedge i_core_clk);
      i_ptr_in_prog = ptr;
      i_skip_cond   = skip;
      fetch.push(w);
      // let the fetch model see the word before the first look
      #1;
      while (!(i_instr_valid === 1'b1 && o_issue_ready === 1'b1 && o_phase === PH_Q4) && k < 40) begin
         @(negedge i_core_clk);
         #1;
         k++;
      end
      chk(64'(k < 40), 64'h1);
      for (k = 0; k < 4 * n; k++) begin
         @(negedge i_core_clk);
         #1;
         rd_n = rd_n + 4'(o_reg_rd);
         wr_n = wr_n + 4'(o_reg_wr);
         fl_n = fl_n + 4'(o_flush);
         lo_n = lo_n + 4'(!o_issue_ready);
         if (o_phase !== cid_phase_type'(k[1:0])) ph_bad = ph_bad + 4'h1;
         if (k == 0) at[4] = o_active & o_first_cyc;
         if (k == 1) at[3] = o_reg_rd;
         if (k == 3) at[2:1] = {o_reg_wr, o_reg_wr & o_wr_acc};
         // flush is registered at the closing Q4 edge, so it stands in the clock after it
         if (k == 4) at[0] = o_flush;
      end
      chk({rd_n, wr_n, fl_n, lo_n, ph_bad, at},
          {4'(e[3]), 4'(e[2]), 4'(e[0]), 4'(4 * (n - 1)), 4'h0, 1'b1, e});
   endtask : run

   // ****
   // scenarios
   // ****
   task automatic t_byte_ops;
      run(14'h077F, 2'h0, 1'b0, 1, 4'hE);
      chk({o_fields.fmt, o_fields.dest_file, o_fields.reg_loc}, {FMT_BYTE, 1'b0, 7'h7F});
      run(14'h0785, 2'h3, 1'b0, 1, 4'hC);
      chk({o_fields.dest_file, o_fields.reg_loc}, {1'b1, 7'h05});
   endtask : t_byte_ops

   task automatic t_indirect;
      run(14'h0781, 2'h1, 1'b0, 1, 4'hC);
      chk(64'(o_extra_cyc), 64'h0);
      run(14'h0781, 2'h2, 1'b0, 2, 4'hC);
      chk(64'(o_fields.ptr_sel), 64'h1);
      chk(64'(o_extra_cyc), 64'h1);
      run(14'h1C00, 2'h1, 1'b1, 3, 4'h9);
   endtask : t_indirect

   task automatic t_bit_ops;
      run(14'h1790, 2'h0, 1'b0, 1, 4'hC);
      chk({o_fields.fmt, o_fields.bit_pos, o_fields.reg_loc}, {FMT_BIT, 3'h7, 7'h10});
      run(14'h107F, 2'h0, 1'b0, 1, 4'hC);
      chk({o_fields.bit_pos, o_fields.reg_loc}, {3'h0, 7'h7F});
   endtask : t_bit_ops

   task automatic t_skips;
      run(14'h1C03, 2'h0, 1'b1, 2, 4'h9);
      run(14'h1803, 2'h0, 1'b0, 2, 4'h8);
      run(14'h0B84, 2'h0, 1'b1, 2, 4'hD);
      run(14'h0F04, 2'h0, 1'b0, 2, 4'hE);
   endtask : t_skips

   task automatic t_flow;
      logic [13:0] ops [7] = '{14'h2800, 14'h3200, 14'h000A, 14'h000B, 14'h0008, 14'h0009, 14'h34A5};
      run(14'h27FF, 2'h0, 1'b0, 2, 4'h1);
      chk({o_fields.fmt, o_fields.target}, {FMT_LIT, 11'h7FF});
      foreach (ops[i]) run(ops[i], 2'h0, 1'b0, 2, 4'h1);
      chk(64'(o_fields.literal), 64'hA5);
   endtask : t_flow

   task automatic t_literal;
      run(14'h30A5, 2'h0, 1'b0, 1, 4'h0);
      chk({o_fields.fmt, o_fields.literal}, {FMT_LIT, 8'hA5});
      run(14'h0000, 2'h3, 1'b0, 1, 4'h0);
   endtask : t_literal

   task automatic t_ptr_step;
      cid_fields_type f;
      for (int m = 0; m < 4; m++) begin
         run(14'h0010 | 14'(m), 2'h2, 1'b0, 1, 4'h0);
         chk({o_fields.step, o_fields.ptr_sel}, {2'(m), 1'b0});
      end
      run(14'h0016, 2'h2, 1'b0, 2, 4'h0);
      f = o_fields;
      run(14'h001E, 2'h2, 1'b0, 2, 4'h0);
      chk({o_fields.fmt, o_fields.op, o_fields.step, o_fields.ptr_sel}, {f.fmt, f.op, f.step, f.ptr_sel});
   endtask : t_ptr_step

   // ****
   // main sequence
   // ****
   initial begin
      i_core_clk = 1'b0;
      forever #4 i_core_clk = ~i_core_clk;
   end

   // the whole run needs a few hundred clocks; this limit only catches a hang
   initial begin
      #200000;
      mismatches++;
      close_out();
   end

   initial begin
      mismatches    = 0;
      checked       = 0;
      i_rst         = 1'b1;
      i_ptr_in_prog = 2'h0;
      i_skip_cond   = 1'b0;
      repeat (6) @(negedge i_core_clk);
      i_rst = 1'b0;
      chk({o_issue_ready, o_active, o_flush, o_reg_rd, o_reg_wr}, 64'h10);
      t_byte_ops();
      t_indirect();
      t_bit_ops();
      t_skips();
      t_flow();
      t_literal();
      t_ptr_step();
      close_out();
   end

endmodule : cid_decode_timing_tb
